//--- verilog/srg_top.sv
/*
 * Supply reset and RAM guard: supervises a supply-low indication, drives
 * the system reset with a hold period and guards the RAM chip enable.
 * Assumes CORE_CLK_I runs always, even while the supply is low; the
 * supply-low and backup indications are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Reset asserted while supply is low.
// - Hold reset about 200ms after recovery.
// - Reset output is active low.
// - Filter glitches on supply-low indication.
// - RAM select held inactive on backup power.
// - Block RAM in reset; buffer disable high.
// - Power-down chip enable inactive high.
// - Direct CPU reset; DSP reset also CPU-driven.
module srg_top
    import srg_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYC,
    parameter int unsigned FILT_CYCLES = FILT_CYC
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // Supply monitor pins
    input wire logic SUPPLY_LOW_I,
    input wire logic ON_BATTERY_I,
    // Processor side
    input wire logic CPU_RAM_CS_N_I,
    input wire logic CPU_DSP_RST_N_I,
    // Reset outputs
    output logic CPU_RST_N_O,
    output logic DSP_RST_N_O,
    // RAM guard
    output logic RAM_CE_N_O,
    output logic BUF_DIS_O
);
    localparam int HW = $clog2(HOLD_CYCLES + 1);

    logic [1:0] low_sync_q;
    logic [1:0] bat_sync_q;
    logic [1:0] cs_sync_q;
    logic low_filt;
    srg_state_t state_q;
    logic [HW-1:0] hold_q;
    logic rst_n_q;
    logic dis_q;
    logic dsp_rst_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for asynchronous pins
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            low_sync_q <= 2'h3;
            bat_sync_q <= 2'h3;
            cs_sync_q <= 2'h3;
        end else begin
            low_sync_q <= {low_sync_q[0], SUPPLY_LOW_I};
            bat_sync_q <= {bat_sync_q[0], ON_BATTERY_I};
            cs_sync_q <= {cs_sync_q[0], CPU_RAM_CS_N_I};
        end
    end

    // Short transients never reach the supervisor
    srg_filter #(
        .COUNT(FILT_CYCLES)
    ) u_filter (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .raw_i(low_sync_q[1]),
        .filt_o(low_filt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supervisor state: low, hold, run
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state_q <= SRG_LOW;
        end else if (low_filt) begin
            state_q <= SRG_LOW; // Any reassertion restarts
        end else begin
            unique case (state_q)
                SRG_LOW: state_q <= SRG_HOLD;
                SRG_HOLD: begin
                    if (hold_q == HW'(HOLD_CYCLES - 1)) begin
                        state_q <= SRG_RUN;
                    end
                end
                SRG_RUN: state_q <= SRG_RUN;
                default: state_q <= SRG_LOW; // Unused code falls to held
            endcase
        end
    end

    // Hold counter, cleared outside the hold state
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            hold_q <= '0;
        end else if (state_q == SRG_HOLD && !low_filt) begin
            hold_q <= hold_q + HW'(1);
        end else begin
            hold_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset output register; low means held
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            rst_n_q <= RST_ON;
        end else if (state_q == SRG_RUN && !low_filt) begin
            rst_n_q <= RST_OFF;
        end else begin
            rst_n_q <= RST_ON;
        end
    end

    // DSP reset: supervisor reset or the processor's own control
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            dsp_rst_n_q <= RST_ON;
        end else begin
            dsp_rst_n_q <= rst_n_q & CPU_DSP_RST_N_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access block: supervisor reset, transition or battery operation.
    // The filter output is watched too, so blocking starts a cycle early
    logic dis_d;
    always_comb begin
        dis_d = !rst_n_q || low_filt || state_q != SRG_RUN
            || bat_sync_q[1];
    end

    // Buffer disable register
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            dis_q <= 1'b1;
        end else begin
            dis_q <= dis_d;
        end
    end

    // Chip enable from a flop, forced high while blocked
    // Taking the block on the same edge as the buffer disable covers the
    // first reset cycle; the enable opens a cycle after the buffer does
    logic ce_n_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ce_n_q <= 1'b1;
        end else begin
            ce_n_q <= cs_sync_q[1] | dis_q | dis_d;
        end
    end

    assign CPU_RST_N_O = rst_n_q; // Direct to the processor
    assign DSP_RST_N_O = dsp_rst_n_q;
    assign RAM_CE_N_O = ce_n_q;
    assign BUF_DIS_O = dis_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_low;
        low_filt;
    endsequence

    property p_low_holds_reset;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_low |=> !CPU_RST_N_O;
    endproperty
    a_low_holds_reset: assert property (p_low_holds_reset)
        else $error("reset released while supply low");

    property p_release_cause;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(CPU_RST_N_O) |-> $past(state_q) == SRG_RUN;
    endproperty
    a_release_cause: assert property (p_release_cause)
        else $error("reset released without finished hold");

    property p_hold_ends;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (state_q == SRG_HOLD && hold_q == HW'(HOLD_CYCLES - 1)
            && !low_filt) |=> state_q == SRG_RUN;
    endproperty
    a_hold_ends: assert property (p_hold_ends)
        else $error("hold did not end at full count");

    property p_active_low;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        state_q != SRG_RUN |=> !CPU_RST_N_O;
    endproperty
    a_active_low: assert property (p_active_low)
        else $error("reset level high outside run");

    property p_restart;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (state_q == SRG_HOLD && low_filt) |=> hold_q == '0
            ##1 hold_q == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold count not restarted");

    property p_glitch;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(low_filt) |-> $past(low_sync_q[1], 1)
            && $past(low_sync_q[1], 2);
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("filter passed a short pulse");

    // Run length of the synchronised supply-low level, saturating
    localparam int FW = $clog2(FILT_CYCLES + 1);
    logic [FW-1:0] low_run_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            low_run_q <= '0;
        end else if (!low_sync_q[1]) begin
            low_run_q <= '0;
        end else if (low_run_q != FW'(FILT_CYCLES)) begin
            low_run_q <= low_run_q + FW'(1);
        end
    end

    property p_filter_len;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(low_filt) |-> low_run_q == FW'(FILT_CYCLES);
    endproperty
    a_filter_len: assert property (p_filter_len)
        else $error("filter passed a short supply-low run");

    property p_battery;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        bat_sync_q[1] |=> RAM_CE_N_O && BUF_DIS_O;
    endproperty
    a_battery: assert property (p_battery)
        else $error("RAM enabled on battery");

    property p_block;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !CPU_RST_N_O |=> BUF_DIS_O ##1 RAM_CE_N_O;
    endproperty
    a_block: assert property (p_block)
        else $error("RAM not blocked during reset");

    property p_block_now;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !CPU_RST_N_O |-> BUF_DIS_O && RAM_CE_N_O;
    endproperty
    a_block_now: assert property (p_block_now)
        else $error("RAM open in a reset cycle");

    property p_ce_off;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        BUF_DIS_O |=> RAM_CE_N_O;
    endproperty
    a_ce_off: assert property (p_ce_off)
        else $error("chip enable low while gated");

    property p_dsp;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (!CPU_RST_N_O || !CPU_DSP_RST_N_I) |=> !DSP_RST_N_O;
    endproperty
    a_dsp: assert property (p_dsp)
        else $error("DSP reset not followed");
endmodule
`default_nettype wire

//--- verilog/srg_pkg.sv
/*
 * Package for the supply reset and RAM guard: timing constants and the
 * supervisor state type.
 * Assumes a 50 MHz always-on core clock.
 */
package srg_pkg;
    // Core clock rate
    localparam int unsigned CLK_HZ = 50_000_000;
    // Hold time after supply recovery, in milliseconds
    localparam int unsigned HOLD_MS = 200;
    // Hold time in cycles (longest time, rounds down)
    localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    // Glitch filter time in microseconds
    localparam int unsigned FILT_US = 10;
    // Glitch filter time in cycles
    localparam int unsigned FILT_CYC = (CLK_HZ / 1_000_000) * FILT_US;
    // Reset output levels (active low)
    localparam logic RST_ON = 1'b0;
    localparam logic RST_OFF = 1'b1;

    // Supervisor states
    typedef enum logic [1:0] {
        SRG_LOW,
        SRG_HOLD,
        SRG_RUN
    } srg_state_t;
endpackage

//--- verilog/srg_filter.sv
/*
 * Glitch filter for the supply-low indication.
 * Assumes the input is already synchronised to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_filter #(
    parameter int unsigned COUNT = 500
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw and filtered level
    input wire logic raw_i,
    output logic filt_o
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_q;
    logic filt_q;

    ////////////////////////////////////////////////////////////////////////
    // Output follows only after the input has stood still COUNT cycles
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            filt_q <= 1'b1; // Assume supply low until proven otherwise
        end else if (raw_i == filt_q) begin
            cnt_q <= '0;
        end else if (cnt_q == W'(COUNT - 1)) begin
            cnt_q <= '0;
            filt_q <= raw_i;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
    assign filt_o = filt_q;
endmodule
`default_nettype wire

//--- verification/srg_cpu_model.sv
/*
 * Processor model facing the supply reset and RAM guard.
 * Assumes it runs on the guard's core clock and obeys its reset.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_cpu_model (
    // Clock and system reset from the guard
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench request to park the DSP
    input wire logic dsp_off_i,
    // Processor outputs
    output logic ram_cs_n_o,
    output logic dsp_rst_n_o
);
    logic [2:0] cnt_q;
    // RAM select toggles every 8 cycles; idle while held in reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
            ram_cs_n_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                ram_cs_n_o <= !ram_cs_n_o;
            end
        end
    end
    // Own DSP reset for duty cycling, apart from the system reset
    assign dsp_rst_n_o = !dsp_off_i;
endmodule
`default_nettype wire

//--- verification/tb_srg_top.sv
/*
 * Self-checking bench for the supply reset and RAM guard.
 * Assumes short hold and filter counts set by parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_srg_top;
    localparam int unsigned HOLD = 20;
    localparam int unsigned FILT = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sup_low = 1'b1;
    logic on_batt = 1'b0;
    logic dsp_off = 1'b0;
    logic cs_n, cpu_dsp_n, cpu_rst_n, dsp_rst_n, ce_n, buf_dis;
    logic [3:0] cs_h;
    int fails = 0;
    int n_tests = 0;
    int n;
    // Clock and a short history of the RAM select
    always #10 clk = !clk;
    always @(posedge clk) cs_h <= {cs_h[2:0], cs_n};
    srg_top #(.HOLD_CYCLES(HOLD), .FILT_CYCLES(FILT)) srg_top_i (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .SUPPLY_LOW_I(sup_low),
        .ON_BATTERY_I(on_batt), .CPU_RAM_CS_N_I(cs_n),
        .CPU_DSP_RST_N_I(cpu_dsp_n), .CPU_RST_N_O(cpu_rst_n),
        .DSP_RST_N_O(dsp_rst_n), .RAM_CE_N_O(ce_n), .BUF_DIS_O(buf_dis));
    srg_cpu_model srg_cpu_model_i (.clk_i(clk), .rst_n_i(cpu_rst_n),
        .dsp_off_i(dsp_off), .ram_cs_n_o(cs_n), .dsp_rst_n_o(cpu_dsp_n));
    task automatic test_done();
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sample one step after the edge so its updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic set_low(input logic v, input int k);
        @(posedge clk);
        sup_low <= v;
        cyc(k);
    endtask
    // Counts cycles to release; a hang here ends the run
    task automatic wait_rel(output int c);
        c = 0;
        while (cpu_rst_n !== 1'b1) begin
            cyc(1);
            c++;
            if (c > 100) begin
                fails++;
                test_done();
            end
        end
    endtask
    task automatic t_powerup();
        cyc(40);
        chk(cpu_rst_n, 1'b0);
        chk(dsp_rst_n, 1'b0);
        chk(buf_dis, 1'b1);
        chk(ce_n, 1'b1);
        set_low(1'b0, 0);
        wait_rel(n);
        chk(n >= HOLD + FILT && n <= HOLD + FILT + 8, 1'b1);
        cyc(2);
        chk(buf_dis, 1'b0);
        // Select passes once it has been steady for the sync delay
        repeat (24) begin
            cyc(1);
            if (cs_h == {4{cs_n}}) chk(ce_n, cs_n);
        end
    endtask
    task automatic t_glitch();
        set_low(1'b1, FILT - 2);
        set_low(1'b0, 20);
        chk(cpu_rst_n, 1'b1);
    endtask
    task automatic t_restart();
        set_low(1'b1, 12);
        chk(cpu_rst_n, 1'b0);
        chk(buf_dis, 1'b1);
        set_low(1'b0, 12);
        chk(cpu_rst_n, 1'b0);
        chk(buf_dis, 1'b1);
        set_low(1'b1, 8);
        set_low(1'b0, 0);
        wait_rel(n);
        chk(n >= HOLD + FILT && n <= HOLD + FILT + 8, 1'b1);
    endtask
    task automatic t_batt();
        @(posedge clk);
        on_batt <= 1'b1;
        cyc(4);
        repeat (20) begin
            cyc(1);
            chk(ce_n, 1'b1);
            chk(buf_dis, 1'b1);
        end
        @(posedge clk);
        on_batt <= 1'b0;
    endtask
    task automatic t_dsp();
        @(posedge clk);
        dsp_off <= 1'b1;
        cyc(3);
        chk(dsp_rst_n, 1'b0);
        chk(cpu_rst_n, 1'b1);
        @(posedge clk);
        dsp_off <= 1'b0;
        cyc(3);
        chk(dsp_rst_n, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_powerup();
        t_glitch();
        t_batt();
        t_dsp();
        t_restart();
        test_done();
    end
endmodule
`default_nettype wire
